// File: scr_regs.svh
// System configuration register bank: offsets, fields, resets and timing
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define SCR_ADDR_PWRMSK 32'h80000000
`define SCR_ADDR_GATES 32'h80000004
`define SCR_ADDR_PIOSEL 32'h80000008
`define SCR_ADDR_AUDCTL 32'h8000000C
`define SCR_ADDR_OTHCFG 32'h80000010
`define SCR_ADDR_TSTCTL 32'h80000014

// ----------------------------------------------------------------
// Key, reset value and writable-bit masks
// ----------------------------------------------------------------
`define SCR_KEY 32'h0000003C
`define SCR_RESET 32'h00000000
`define SCR_MASK_PWRMSK 32'h00000001
`define SCR_MASK_GATES 32'h0000007F
`define SCR_MASK_PIOSEL 32'h0000FFFF
`define SCR_MASK_NONE 32'h00000000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SCR_BIT_RTCACC 0
`define SCR_BIT_DMA 0
`define SCR_BIT_DRAM 1
`define SCR_BIT_AUDTX 2
`define SCR_BIT_AUDRX 3
`define SCR_BIT_NFC 4
`define SCR_BIT_NFB 5
`define SCR_BIT_SYSCLK 6

// ----------------------------------------------------------------
// Bus responses and timing
// ----------------------------------------------------------------
`define SCR_RESP_OKAY 2'h0
`define SCR_RESP_SLVERR 2'h2
`define SCR_SYS_HZ 25000000
`define SCR_RTC_HZ 32768
`define SCR_RTC_HALF (`SCR_SYS_HZ / (2 * `SCR_RTC_HZ))
`define SCR_RTC_SETTLE 4

`endif

// File: scr_pkg.sv
// Types shared by the system configuration register bank
package scr_pkg;

    typedef enum logic [2:0] {
        SCR_SEL_PWRMSK = 3'b000,
        SCR_SEL_GATES = 3'b001,
        SCR_SEL_PIOSEL = 3'b010,
        SCR_SEL_AUDCTL = 3'b011,
        SCR_SEL_OTHCFG = 3'b100,
        SCR_SEL_TSTCTL = 3'b101,
        SCR_SEL_NONE = 3'b111
    } scr_sel_t;

    typedef logic [31:0] scr_word_t;

endpackage : scr_pkg

// File: scr_top.sv
// System configuration register bank with AXI4-Lite slave and pin mux
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "scr_regs.svh"

module scr_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic rtc_access_enable,
    output logic rtc_access_ready,
    output logic rtc_clk_32k,
    output logic dma_clock_stop,
    output logic dram_clock_stop,
    output logic audio_tx_clock_stop,
    output logic audio_rx_clock_stop,
    output logic nand_ctrl_clock_stop,
    output logic nand_buffer_clock_stop,
    output logic sysclk_out_enable,
    output logic sysclk_out_pin,
    output logic [15:0] pin_select,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    output logic [3:0] gpio_in,
    input wire logic audio_tx_bit_clock_out,
    input wire logic audio_tx_bit_clock_oe,
    output logic audio_tx_bit_clock_in,
    input wire logic audio_tx_word_select_out,
    input wire logic audio_tx_word_select_oe,
    output logic audio_tx_word_select_in,
    input wire logic audio_tx_serial_data,
    input wire logic audio_tx_master_clock,
    input wire logic [3:0] pad_in,
    output logic [3:0] pad_out,
    output logic [3:0] pad_oe
);

    // ------------------------------------------------------------
    // Decode and helpers
    // ------------------------------------------------------------
    function automatic scr_pkg::scr_sel_t decode(input logic [31:0] a);
        unique case (a)
            `SCR_ADDR_PWRMSK: decode = scr_pkg::SCR_SEL_PWRMSK;
            `SCR_ADDR_GATES: decode = scr_pkg::SCR_SEL_GATES;
            `SCR_ADDR_PIOSEL: decode = scr_pkg::SCR_SEL_PIOSEL;
            `SCR_ADDR_AUDCTL: decode = scr_pkg::SCR_SEL_AUDCTL;
            `SCR_ADDR_OTHCFG: decode = scr_pkg::SCR_SEL_OTHCFG;
            `SCR_ADDR_TSTCTL: decode = scr_pkg::SCR_SEL_TSTCTL;
            default: decode = scr_pkg::SCR_SEL_NONE;
        endcase
    endfunction : decode

    function automatic logic [31:0] strobe_mask(input logic [3:0] s);
        strobe_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strobe_mask

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    scr_pkg::scr_word_t pwrmsk;
    scr_pkg::scr_word_t gates;
    scr_pkg::scr_word_t piosel;
    logic [5:0] unlocked;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic commit;
    logic is_key;
    logic target_open;
    scr_pkg::scr_sel_t wsel;
    logic [31:0] wmerge_mask;

    assign commit = aw_held && w_held && !s_axi_bvalid;
    assign wsel = decode(aw_addr);
    assign is_key = (w_data == `SCR_KEY) && (w_strb == 4'hF);
    assign target_open = (wsel != scr_pkg::SCR_SEL_NONE)
        && unlocked[wsel];
    assign wmerge_mask = strobe_mask(w_strb);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= 32'h00000000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (commit) begin
            aw_held <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (commit) begin
            w_held <= 1'b0;
        end else if (!w_held && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCR_RESP_OKAY;
        end else if (commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == scr_pkg::SCR_SEL_NONE)
                ? `SCR_RESP_SLVERR : `SCR_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Lock state
    // ------------------------------------------------------------
    // Any write closes every other register, so the key must come
    // immediately before its data.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlocked <= 6'h00;
        end else if (commit) begin
            if (!target_open && is_key
                && wsel != scr_pkg::SCR_SEL_NONE) begin
                unlocked <= 6'(6'h01 << wsel);
            end else begin
                unlocked <= 6'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwrmsk <= `SCR_RESET;
        end else if (commit && target_open
            && wsel == scr_pkg::SCR_SEL_PWRMSK) begin
            pwrmsk <= ((pwrmsk & ~wmerge_mask)
                | (w_data & wmerge_mask)) & `SCR_MASK_PWRMSK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gates <= `SCR_RESET;
        end else if (commit && target_open
            && wsel == scr_pkg::SCR_SEL_GATES) begin
            gates <= ((gates & ~wmerge_mask)
                | (w_data & wmerge_mask)) & `SCR_MASK_GATES;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            piosel <= `SCR_RESET;
        end else if (commit && target_open
            && wsel == scr_pkg::SCR_SEL_PIOSEL) begin
            piosel <= ((piosel & ~wmerge_mask)
                | (w_data & wmerge_mask)) & `SCR_MASK_PIOSEL;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    scr_pkg::scr_sel_t rsel;
    logic [31:0] rword;

    assign rsel = decode(s_axi_araddr);

    always_comb begin
        unique case (rsel)
            scr_pkg::SCR_SEL_PWRMSK: rword = pwrmsk;
            scr_pkg::SCR_SEL_GATES: rword = gates;
            scr_pkg::SCR_SEL_PIOSEL: rword = piosel;
            default: rword = `SCR_MASK_NONE;
        endcase
    end

    // Reads touch no lock state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SCR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rword;
            s_axi_rresp <= (rsel == scr_pkg::SCR_SEL_NONE)
                ? `SCR_RESP_SLVERR : `SCR_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    assign rtc_access_enable = pwrmsk[`SCR_BIT_RTCACC];
    assign dma_clock_stop = gates[`SCR_BIT_DMA];
    assign dram_clock_stop = gates[`SCR_BIT_DRAM];
    assign audio_tx_clock_stop = gates[`SCR_BIT_AUDTX];
    assign audio_rx_clock_stop = gates[`SCR_BIT_AUDRX];
    assign nand_ctrl_clock_stop = gates[`SCR_BIT_NFC];
    assign nand_buffer_clock_stop = gates[`SCR_BIT_NFB];
    assign sysclk_out_enable = gates[`SCR_BIT_SYSCLK];
    assign pin_select = piosel[15:0];

    // Enable changes only at a rising edge while the clock is high,
    // so the pin never glitches low when it switches.
    assign sysclk_out_pin = sysclk_out_enable ? aclk : 1'b1;

    // ------------------------------------------------------------
    // RTC 32 kHz clock and settling
    // ------------------------------------------------------------
    logic [8:0] rtc_div;
    logic [2:0] rtc_settle;

    // Divider rounds down, so the tick runs slightly fast
    always_ff @(posedge aclk) begin
        if (!aresetn || !rtc_access_enable) begin
            rtc_div <= 9'h000;
            rtc_clk_32k <= 1'b0;
        end else if (rtc_div == 9'(`SCR_RTC_HALF - 1)) begin
            rtc_div <= 9'h000;
            rtc_clk_32k <= !rtc_clk_32k;
        end else begin
            rtc_div <= rtc_div + 9'h001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !rtc_access_enable) begin
            rtc_settle <= 3'h0;
            rtc_access_ready <= 1'b0;
        end else if (rtc_settle == 3'(`SCR_RTC_SETTLE)) begin
            rtc_access_ready <= 1'b1;
        end else if (rtc_clk_32k
            && rtc_div == 9'(`SCR_RTC_HALF - 1)) begin
            rtc_settle <= rtc_settle + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Pin function mux
    // ------------------------------------------------------------
    logic [3:0] pad_meta;
    logic [3:0] pad_sync;
    logic [3:0] alt_out;
    logic [3:0] alt_oe;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_meta <= 4'h0;
            pad_sync <= 4'h0;
        end else begin
            pad_meta <= pad_in;
            pad_sync <= pad_meta;
        end
    end

    assign alt_out = {audio_tx_master_clock, audio_tx_serial_data,
        audio_tx_word_select_out, audio_tx_bit_clock_out};
    assign alt_oe = {1'b1, 1'b1, audio_tx_word_select_oe,
        audio_tx_bit_clock_oe};

    // Lines are registered; pad follows the source one cycle later
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_line
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pad_out[gi] <= 1'b0;
                    pad_oe[gi] <= 1'b0;
                end else if (piosel[gi]) begin
                    pad_out[gi] <= alt_out[gi];
                    pad_oe[gi] <= alt_oe[gi];
                end else begin
                    pad_out[gi] <= gpio_out[gi];
                    pad_oe[gi] <= gpio_oe[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gpio_in <= 4'h0;
            audio_tx_bit_clock_in <= 1'b0;
            audio_tx_word_select_in <= 1'b0;
        end else begin
            gpio_in <= pad_sync;
            audio_tx_bit_clock_in <= piosel[0] && pad_sync[0];
            audio_tx_word_select_in <= piosel[1] && pad_sync[1];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    localparam int RTC_LAST = `SCR_RTC_HALF - 1;

    a_key_unlock: assert property (
        commit && !target_open && is_key
        && wsel == scr_pkg::SCR_SEL_GATES
        |=> unlocked == 6'h02)
        else $error("key write did not unlock register");

    a_nonkey_locked: assert property (
        commit && !target_open && !is_key
        |=> unlocked == 6'h00 && $stable(pwrmsk)
        && $stable(gates) && $stable(piosel))
        else $error("non-key write changed locked register");

    a_read_no_lock: assert property (
        s_axi_arvalid && s_axi_arready && !commit
        |=> $stable(unlocked))
        else $error("read disturbed lock state");

    a_reserved_zero: assert property (
        (pwrmsk & ~`SCR_MASK_PWRMSK) == 32'h00000000
        && (gates & ~`SCR_MASK_GATES) == 32'h00000000
        && (piosel & ~`SCR_MASK_PIOSEL) == 32'h00000000)
        else $error("reserved bit set");

    a_rtc_clk_off: assert property (
        !rtc_access_enable |=> !rtc_clk_32k ##1 !rtc_clk_32k
        or rtc_access_enable)
        else $error("rtc clock runs while disabled");

    a_rtc_toggle: assert property (
        rtc_access_enable && rtc_div == RTC_LAST[8:0]
        ##1 rtc_access_enable |-> $changed(rtc_clk_32k))
        else $error("rtc clock missed its toggle");

    a_stop_write: assert property (
        commit && target_open && wsel == scr_pkg::SCR_SEL_GATES
        && w_strb[0]
        |=> dma_clock_stop == $past(w_data[`SCR_BIT_DMA])
        && dram_clock_stop == $past(w_data[`SCR_BIT_DRAM]))
        else $error("clock stop bits not written");

    a_single_write: assert property (
        commit && target_open |=> unlocked == 6'h00
        ##1 !commit [*1] or commit)
        else $error("unlock outlived one write");

    a_sdata_drive: assert property (
        piosel[2] |=> pad_oe[2]
        && pad_out[2] == $past(audio_tx_serial_data))
        else $error("line 2 not carrying serial data");

    a_gpio_route: assert property (
        !piosel[0] |=> pad_out[0] == $past(gpio_out[0])
        && pad_oe[0] == $past(gpio_oe[0]))
        else $error("line 0 not routed to gpio");

    a_reset_clear: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> unlocked == 6'h00 && pwrmsk == `SCR_RESET
        && gates == `SCR_RESET && piosel == `SCR_RESET)
        else $error("reset left state behind");

    c_key_then_data: cover property (
        commit && is_key ##[1:20] commit && target_open);
    c_rtc_rise: cover property ($rose(rtc_clk_32k));
    c_line0_alt: cover property (piosel[0] && pad_oe[0]);
    c_unmapped: cover property (
        s_axi_rvalid && s_axi_rresp == `SCR_RESP_SLVERR);

endmodule : scr_top

// File: scr_cpu_model.sv
// Bus master model standing in for the processor core
`timescale 1ns/1ps
module scr_cpu_model (
    input wire logic aclk,
    output logic [31:0] s_axi_awaddr,
    output logic [2:0] s_axi_awprot,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [31:0] s_axi_araddr,
    output logic [2:0] s_axi_arprot,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    bit hung;
    initial begin
        hung = 0;
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid} = '0;
        {s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
        // Whole-word writes only, so a key always lands complete
        s_axi_wstrb = 4'hF;
    end

    // ----------------------------------------------------------------
    // Transfers; payload is scrambled once taken, never left stale
    // ----------------------------------------------------------------
    task automatic do_write(input logic [31:0] a, input logic [31:0] d,
                            output logic [1:0] r);
        bit pa;
        bit pw;
        int n;
        pa = 1;
        pw = 1;
        n = 0;
        r = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (pa && s_axi_awready) begin
                pa = 0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (pw && s_axi_wready) begin
                pw = 0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (!(s_axi_bvalid && !pa && !pw) && n < 500);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 500) hung = 1;
    endtask : do_write

    task automatic do_read(input logic [31:0] a, output logic [31:0] d,
                           output logic [1:0] r);
        bit pa;
        int n;
        pa = 1;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (pa && s_axi_arready) begin
                pa = 0;
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!(s_axi_rvalid && !pa) && n < 500);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 500) hung = 1;
    endtask : do_read
endmodule : scr_cpu_model

// File: testbench.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`include "scr_regs.svh"
`define CHK(n, e, s) \
    begin \
        num_checks++; \
        if ((s) !== (e)) begin \
            errors++; \
            $display("wrong value %s exp %0h got %0h", n, e, s); \
        end \
    end
module testbench;
    logic aclk, aresetn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic rtc_access_enable, rtc_access_ready, rtc_clk_32k;
    logic dma_clock_stop, dram_clock_stop, audio_tx_clock_stop;
    logic audio_rx_clock_stop, nand_ctrl_clock_stop, nand_buffer_clock_stop;
    logic sysclk_out_enable, sysclk_out_pin;
    logic [15:0] pin_select;
    logic [3:0] gpio_out, gpio_oe, gpio_in, pad_in, pad_out, pad_oe;
    logic audio_tx_bit_clock_out, audio_tx_bit_clock_oe;
    logic audio_tx_bit_clock_in, audio_tx_word_select_out;
    logic audio_tx_word_select_oe, audio_tx_word_select_in;
    logic audio_tx_serial_data, audio_tx_master_clock;
    int errors, num_checks, open_idx, t, n;
    int unsigned mreg[6];
    logic [1:0] resp;
    logic [31:0] rd;

    scr_top i_scr_top (.*);
    scr_cpu_model i_scr_cpu_model (.*);

    // ----------------------------------------------------------------
    // Reference model and helpers
    // ----------------------------------------------------------------
    function automatic int unsigned mask_of(int i);
        case (i)
            0: return `SCR_MASK_PWRMSK;
            1: return `SCR_MASK_GATES;
            2: return `SCR_MASK_PIOSEL;
            default: return `SCR_MASK_NONE;
        endcase
    endfunction : mask_of

    task automatic close_out;
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic hang_check;
        if (i_scr_cpu_model.hung) begin
            errors++;
            close_out();
        end
    endtask : hang_check

    task automatic check_outs;
        #1;
        `CHK("rtc_en", mreg[0][0], rtc_access_enable)
        `CHK("dma", mreg[1][0], dma_clock_stop)
        `CHK("dram", mreg[1][1], dram_clock_stop)
        `CHK("aud_tx", mreg[1][2], audio_tx_clock_stop)
        `CHK("aud_rx", mreg[1][3], audio_rx_clock_stop)
        `CHK("nfc", mreg[1][4], nand_ctrl_clock_stop)
        `CHK("nfb", mreg[1][5], nand_buffer_clock_stop)
        `CHK("sck_en", mreg[1][6], sysclk_out_enable)
        `CHK("sel", mreg[2][15:0], pin_select)
    endtask : check_outs

    task automatic bus_wr(int i, int unsigned d);
        logic [1:0] er;
        er = (i > 5) ? `SCR_RESP_SLVERR : `SCR_RESP_OKAY;
        i_scr_cpu_model.do_write(`SCR_ADDR_PWRMSK + 32'(4 * i), d, resp);
        if (i > 5) open_idx = -1;
        else if (open_idx == i) begin
            mreg[i] = d & mask_of(i);
            open_idx = -1;
        end else open_idx = (d == `SCR_KEY) ? i : -1;
        `CHK("bresp", er, resp)
        hang_check();
        check_outs();
    endtask : bus_wr

    task automatic bus_rd(int i);
        int unsigned e;
        logic [1:0] er;
        e = (i > 5) ? 0 : mreg[i];
        er = (i > 5) ? `SCR_RESP_SLVERR : `SCR_RESP_OKAY;
        i_scr_cpu_model.do_read(`SCR_ADDR_PWRMSK + 32'(4 * i), rd, resp);
        `CHK("rdata", e, rd)
        `CHK("rresp", er, resp)
        hang_check();
    endtask : bus_rd

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (mreg[j]) mreg[j] = 0;
        open_idx = -1;
        repeat (2) @(posedge aclk);
    endtask : do_reset

    task automatic count_rtc(int cycles);
        logic p;
        t = 0;
        p = rtc_clk_32k;
        repeat (cycles) begin
            @(posedge aclk);
            #1;
            if (rtc_clk_32k !== p) t++;
            p = rtc_clk_32k;
        end
    endtask : count_rtc

    task automatic check_pins;
        logic [3:0] s, eo, ee;
        s = mreg[2][3:0];
        eo[0] = s[0] ? audio_tx_bit_clock_out : gpio_out[0];
        ee[0] = s[0] ? audio_tx_bit_clock_oe : gpio_oe[0];
        eo[1] = s[1] ? audio_tx_word_select_out : gpio_out[1];
        ee[1] = s[1] ? audio_tx_word_select_oe : gpio_oe[1];
        eo[2] = s[2] ? audio_tx_serial_data : gpio_out[2];
        ee[2] = s[2] | gpio_oe[2];
        eo[3] = s[3] ? audio_tx_master_clock : gpio_out[3];
        ee[3] = s[3] | gpio_oe[3];
        `CHK("pad_out", eo, pad_out)
        `CHK("pad_oe", ee, pad_oe)
        `CHK("gpio_in", pad_in, gpio_in)
        `CHK("bclk_in", s[0] & pad_in[0], audio_tx_bit_clock_in)
        `CHK("ws_in", s[1] & pad_in[1], audio_tx_word_select_in)
    endtask : check_pins

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        aresetn = 1'b0;
        {gpio_out, gpio_oe, pad_in} = '0;
        {audio_tx_bit_clock_out, audio_tx_bit_clock_oe} = '0;
        {audio_tx_word_select_out, audio_tx_word_select_oe} = '0;
        {audio_tx_serial_data, audio_tx_master_clock} = '0;
        errors = 0;
        num_checks = 0;
        void'($urandom(60));
        do_reset();
        for (int i = 0; i < 7; i++) bus_rd(i);
        for (int i = 0; i < 7; i++) begin
            bus_wr(i, 32'hFFFFFFFF);
            bus_wr(i, `SCR_KEY);
            bus_rd(i);
            bus_wr(i, 32'hFFFFFFFF);
            bus_wr(i, 32'h0);
            bus_rd(i);
        end
        bus_wr(1, `SCR_KEY);
        bus_wr(1, `SCR_KEY);
        bus_rd(1);
        // Random mix keeps keys and stray writes interleaved
        repeat (80) begin
            n = $urandom_range(6);
            if ($urandom_range(2) == 0) bus_rd(n);
            else bus_wr(n, $urandom_range(1) ? `SCR_KEY : $urandom);
        end
        bus_wr(0, `SCR_KEY);
        do_reset();
        bus_wr(0, 32'h1);
        for (int i = 0; i < 3; i++) bus_rd(i);
        for (int v = 0; v < 2; v++) begin
            bus_wr(1, `SCR_KEY);
            bus_wr(1, 32'(v << 6));
            @(posedge aclk);
            #30;
            `CHK("sysclk", v ? 1'b0 : 1'b1, sysclk_out_pin)
        end
        count_rtc(1000);
        `CHK("rtc_idle", 0, t)
        bus_wr(0, `SCR_KEY);
        bus_wr(0, 32'h1);
        count_rtc(4 * `SCR_RTC_HALF);
        `CHK("rtc_toggles", 1'b1, t >= 3 && t <= 5)
        `CHK("rtc_early", 1'b0, rtc_access_ready)
        for (n = 0; n < 8 * `SCR_RTC_HALF && rtc_access_ready !== 1'b1; n++)
            @(posedge aclk);
        `CHK("rtc_ready", 1'b1, rtc_access_ready)
        bus_wr(0, `SCR_KEY);
        bus_wr(0, 32'h0);
        repeat (2) @(posedge aclk);
        #1;
        `CHK("rtc_off", 1'b0, rtc_clk_32k)
        for (int s = 0; s < 16; s++) begin
            bus_wr(2, `SCR_KEY);
            bus_wr(2, ($urandom & 32'hFFF0) | 32'(s));
            @(posedge aclk);
            {gpio_out, gpio_oe, pad_in} <= 12'($urandom);
            {audio_tx_bit_clock_out, audio_tx_bit_clock_oe,
             audio_tx_word_select_out, audio_tx_word_select_oe,
             audio_tx_serial_data, audio_tx_master_clock} <= 6'($urandom);
            repeat (4) @(posedge aclk);
            #1;
            check_pins();
        end
        close_out();
    end
endmodule : testbench
